// ===== design/bmx_exec_unit.sv
`timescale 1ns/1ps
// Contract
// - Clear-bit forces the chosen bit of the working register to zero and keeps all other bits.
// - Set-bit forces the chosen bit of the working register to one and keeps all other bits.
// - Clear-bit, set-bit and jump-if-bit-clear never touch the flag register.
// - Opcode 77 is two bytes and four cycles; byte two holds register, bit index, and clear(0)/set(1).
// - Bit-OR ORs the chosen bit of the byte-three register with bit zero of the working register into the destination bit only.
// - After bit-OR, zero flag mirrors a zero result, sign is cleared, overflow undefined, carry, D and H kept.
// - Opcode 07 is three bytes and six cycles; byte-two bit zero picks which operand is the destination.
// - Jump-if-bit-clear adds the displacement to the program counter when the tested bit is zero.
// - Opcode 37 with byte-two bit zero clear is three bytes and ten cycles; byte three is the displacement.
// - The displacement is a signed byte so targets lie from 128 back to 127 forward.
// - Opcode 37 with byte-two bit zero set jumps only when the tested bit is one.
module bmx_exec_unit
    import bmx_pkg::*;
#(
    parameter int PC_W = 16
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic            start,
    input  wire logic [7:0]      opcode,
    input  wire logic [7:0]      byte2,
    input  wire logic [7:0]      byte3,
    input  wire logic [PC_W-1:0] pc_next,
    input  wire logic [3:0]      reg_ptr,
    input  wire logic [7:0]      flags_in,
    input  wire logic [7:0]      rf_rdata,
    output logic                 busy,
    output logic [7:0]           rf_raddr,
    output logic                 rf_we,
    output logic [7:0]           rf_waddr,
    output logic [7:0]           rf_wdata,
    output logic                 flags_we,
    output logic [7:0]           flags_wdata,
    output logic                 pc_load,
    output logic [PC_W-1:0]      pc_target,
    output logic                 done
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        bmx_st_t         st;
        bmx_op_t         op;
        logic [3:0]      cnt;
        logic [3:0]      last;
        logic [3:0]      rp;
        logic [7:0]      b2;
        logic [7:0]      b3;
        logic [PC_W-1:0] pcn;
        logic [7:0]      a_val;
        logic [7:0]      b_val;
        logic            rf_we;
        logic [7:0]      rf_waddr;
        logic [7:0]      rf_wdata;
        logic            flags_we;
        logic [7:0]      flags_wdata;
        logic            pc_load;
        logic [PC_W-1:0] pc_target;
        logic            done;
    } bmx_state_t;

    bmx_state_t      s_r;
    bmx_state_t      s_nxt;

    logic            sel;
    logic [2:0]      idx;
    logic [7:0]      wreg;
    logic [7:0]      addr_a;
    logic [7:0]      addr_b;
    logic            legal;
    bmx_mode_t       op_mode;
    logic [2:0]      op_idx;
    logic            op_or_in;
    logic [7:0]      res_byte;
    logic            res_bit;
    logic            taken;
    logic [PC_W-1:0] disp_ext;
    logic [7:0]      dst_mask;

    // ****************************************
    // Operand decode
    // ****************************************
    assign sel      = s_r.b2[B2_SEL];
    assign idx      = s_r.b2[B2_IDX_HI:B2_IDX_LO];
    assign wreg     = {s_r.rp, s_r.b2[B2_REG_HI:B2_REG_LO]};
    assign legal    = (opcode == OPC_BIT_CS) || (opcode == OPC_BIT_OR) || (opcode == OPC_BIT_JMP);
    assign disp_ext = {{(PC_W-BYTE_W){s_r.b3[DISP_SIGN]}}, s_r.b3};
    assign dst_mask = sel ? (BIT0_MASK << idx) : BIT0_MASK;

    always_comb begin
        // Operand A is always the register that gets written back
        addr_a = wreg;
        addr_b = s_r.b3;
        if (s_r.op == BMX_OP_OR && sel) begin
            addr_a = s_r.b3;
            addr_b = wreg;
        end
    end

    assign rf_raddr = (s_r.cnt == CNT_RD_B) ? addr_b : addr_a;

    always_comb begin
        op_mode  = BMX_MODE_OR;
        op_idx   = idx;
        op_or_in = 1'b0;
        case (s_r.op)
            BMX_OP_CS: begin
                op_mode = sel ? BMX_MODE_SET : BMX_MODE_CLR;
            end
            BMX_OP_OR: begin
                op_idx   = sel ? idx : IDX_ZERO;
                op_or_in = sel ? s_r.b_val[IDX_ZERO] : s_r.b_val[idx];
            end
            default: begin
                op_mode = BMX_MODE_OR;
            end
        endcase
    end

    bmx_bit_op #(
        .W       (BYTE_W),
        .IW      (IDX_W)
    ) u_bit_op (
        .val     (s_r.a_val),
        .idx     (op_idx),
        .mode    (op_mode),
        .or_in   (op_or_in),
        .res     (res_byte),
        .res_bit (res_bit)
    );

    // Same test serves both branch senses: sel names the bit value that jumps
    assign taken = (s_r.a_val[idx] == sel);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rf_we    = 1'b0;
        s_nxt.flags_we = 1'b0;
        s_nxt.pc_load  = 1'b0;
        s_nxt.done     = 1'b0;
        case (s_r.st)
            BMX_IDLE: begin
                // Unsupported opcodes are left to other execution paths
                if (start && legal) begin
                    s_nxt.st  = BMX_RUN;
                    s_nxt.cnt = CNT_FIRST;
                    s_nxt.rp  = reg_ptr;
                    s_nxt.b2  = byte2;
                    s_nxt.b3  = byte3;
                    s_nxt.pcn = pc_next;
                    if (opcode == OPC_BIT_CS) begin
                        s_nxt.op   = BMX_OP_CS;
                        s_nxt.last = CYC_CS;
                    end else if (opcode == OPC_BIT_OR) begin
                        s_nxt.op   = BMX_OP_OR;
                        s_nxt.last = CYC_OR;
                    end else begin
                        s_nxt.op   = BMX_OP_JMP;
                        s_nxt.last = CYC_JMP;
                    end
                end
            end
            BMX_RUN: begin
                if (s_r.cnt == CNT_RD_A) begin
                    s_nxt.a_val = rf_rdata;
                end
                if (s_r.cnt == CNT_RD_B && s_r.op == BMX_OP_OR) begin
                    s_nxt.b_val = rf_rdata;
                end
                if (s_r.cnt == s_r.last - CNT_FIRST) begin
                    s_nxt.st       = BMX_IDLE;
                    s_nxt.done     = 1'b1;
                    s_nxt.rf_waddr = addr_a;
                    s_nxt.rf_wdata = res_byte;
                    s_nxt.rf_we    = (s_r.op != BMX_OP_JMP);
                    // Flags only ever move on bit-OR; overflow is kept as is
                    s_nxt.flags_we = (s_r.op == BMX_OP_OR);
                    s_nxt.flags_wdata        = flags_in;
                    s_nxt.flags_wdata[FLG_Z] = ~res_bit;
                    s_nxt.flags_wdata[FLG_S] = 1'b0;
                    s_nxt.pc_load   = (s_r.op == BMX_OP_JMP) && taken;
                    s_nxt.pc_target = s_r.pcn + disp_ext;
                end else begin
                    s_nxt.cnt = s_r.cnt + CNT_FIRST;
                end
            end
            default: begin
                s_nxt.st = BMX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign busy        = (s_r.st == BMX_RUN);
    assign rf_we       = s_r.rf_we;
    assign rf_waddr    = s_r.rf_waddr;
    assign rf_wdata    = s_r.rf_wdata;
    assign flags_we    = s_r.flags_we;
    assign flags_wdata = s_r.flags_wdata;
    assign pc_load     = s_r.pc_load;
    assign pc_target   = s_r.pc_target;
    assign done        = s_r.done;

    // ****************************************
    // Assertions
    // ****************************************
    // Sampled only on enabled edges, since a low enable freezes every step
    default clocking bmx_cb @(posedge clk iff ce);
    endclocking
    default disable iff (rst);

    sequence seq_start_cs;
        !busy && start && opcode == OPC_BIT_CS;
    endsequence

    sequence seq_start_or;
        !busy && start && opcode == OPC_BIT_OR;
    endsequence

    sequence seq_start_jmp;
        !busy && start && opcode == OPC_BIT_JMP;
    endsequence

    clr_bit_a: assert property (done && s_r.op == BMX_OP_CS && !sel |->
        rf_we && rf_wdata[idx] == 1'b0 && ((rf_wdata ^ s_r.a_val) & ~(BIT0_MASK << idx)) == 8'h00)
        else $error("clear-bit result wrong");

    set_bit_a: assert property (done && s_r.op == BMX_OP_CS && sel |->
        rf_we && rf_wdata[idx] == 1'b1 && ((rf_wdata ^ s_r.a_val) & ~(BIT0_MASK << idx)) == 8'h00)
        else $error("set-bit result wrong");

    flags_hold_a: assert property (flags_we |-> s_r.op == BMX_OP_OR && done)
        else $error("flags written by non bit-OR");

    cs_length_a: assert property (seq_start_cs |=> busy [*3] ##1 (done && rf_we && !busy))
        else $error("bit clear/set length wrong");

    or_keep_a: assert property (done && s_r.op == BMX_OP_OR |->
        rf_we && rf_waddr == addr_a && ((rf_wdata ^ s_r.a_val) & ~dst_mask) == 8'h00)
        else $error("bit-OR disturbed other bits");

    or_flags_a: assert property (flags_we |->
        flags_wdata[FLG_Z] == ~|(rf_wdata & dst_mask) && !flags_wdata[FLG_S]
        && (flags_wdata & FLG_KEEP) == ($past(flags_in) & FLG_KEEP))
        else $error("bit-OR flags wrong");

    or_length_a: assert property (seq_start_or |=> busy [*5] ##1 (done && flags_we && !busy))
        else $error("bit-OR length wrong");

    jmp_test_a: assert property (done && s_r.op == BMX_OP_JMP |->
        pc_load == (s_r.a_val[idx] == s_r.b2[B2_SEL]) && !rf_we)
        else $error("branch decision wrong");

    jmp_length_a: assert property (seq_start_jmp |=> busy [*8] ##1 busy ##1 (done && !busy))
        else $error("bit test jump length wrong");

    jmp_target_a: assert property (seq_start_jmp ##10 pc_load |->
        pc_target == $past(pc_next, 10) + {{(PC_W-BYTE_W){$past(byte3[DISP_SIGN], 10)}}, $past(byte3, 10)})
        else $error("branch target wrong");

    jmp_sense_a: assert property (seq_start_jmp ##10 done |->
        pc_load == ($past(byte2[B2_SEL], 10) == s_r.a_val[idx]))
        else $error("branch sense wrong");

    sequence seq_done_jmp;
        done && s_r.op == BMX_OP_JMP;
    endsequence

    jmp_no_write_a: assert property (seq_done_jmp |-> !rf_we && !flags_we)
        else $error("bit test jump wrote a register or flags");

    // Source and destination may be one register; then the write is the whole story
    or_src_keep_a: assert property (done && s_r.op == BMX_OP_OR && addr_a != addr_b |->
        rf_waddr != addr_b)
        else $error("bit-OR wrote its source");

    // A start during a run is dropped, not queued
    busy_hold_a: assert property (busy && start |=>
        s_r.b2 == $past(s_r.b2) && s_r.b3 == $past(s_r.b3))
        else $error("start taken while busy");

    pc_base_a: assert property (seq_start_jmp |=> s_r.pcn == $past(pc_next))
        else $error("branch base not the next instruction address");

endmodule

// ===== design/bmx_pkg.sv
package bmx_pkg;

    // ****************************************
    // Widths and opcodes
    // ****************************************
    localparam int         BYTE_W      = 8;
    localparam int         IDX_W       = 3;
    localparam int         NIB_W       = 4;
    localparam int         CNT_W       = 4;
    localparam logic [7:0] OPC_BIT_CS  = 8'h77;
    localparam logic [7:0] OPC_BIT_OR  = 8'h07;
    localparam logic [7:0] OPC_BIT_JMP = 8'h37;

    // ****************************************
    // Cycle counts per instruction
    // ****************************************
    localparam logic [3:0] CYC_CS      = 4'h4;
    localparam logic [3:0] CYC_OR      = 4'h6;
    localparam logic [3:0] CYC_JMP     = 4'ha;
    localparam logic [3:0] CNT_FIRST   = 4'h1;
    localparam logic [3:0] CNT_RD_A    = 4'h1;
    localparam logic [3:0] CNT_RD_B    = 4'h2;

    // ****************************************
    // Second operand byte fields
    // ****************************************
    localparam int         B2_REG_HI   = 7;
    localparam int         B2_REG_LO   = 4;
    localparam int         B2_IDX_HI   = 3;
    localparam int         B2_IDX_LO   = 1;
    localparam int         B2_SEL      = 0;
    localparam int         DISP_SIGN   = 7;

    // ****************************************
    // Flag register layout
    // ****************************************
    localparam int         FLG_Z       = 6;
    localparam int         FLG_S       = 5;
    localparam logic [7:0] FLG_KEEP    = 8'h9f;
    localparam logic [7:0] BIT0_MASK   = 8'h01;
    localparam logic [2:0] IDX_ZERO    = 3'h0;

    typedef enum logic [1:0] {
        BMX_MODE_CLR,
        BMX_MODE_SET,
        BMX_MODE_OR
    } bmx_mode_t;

    typedef enum logic [1:0] {
        BMX_OP_CS,
        BMX_OP_OR,
        BMX_OP_JMP
    } bmx_op_t;

    typedef enum logic {
        BMX_IDLE,
        BMX_RUN
    } bmx_st_t;

endpackage

// ===== design/bmx_bit_op.sv
`timescale 1ns/1ps
module bmx_bit_op
    import bmx_pkg::*;
#(
    parameter int W  = BYTE_W,
    parameter int IW = IDX_W
) (
    input  wire logic [W-1:0]  val,
    input  wire logic [IW-1:0] idx,
    input  wire bmx_mode_t     mode,
    input  wire logic          or_in,
    output logic [W-1:0]       res,
    output logic               res_bit
);

    // ****************************************
    // One selected bit changes, all others pass
    // ****************************************
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            if (idx == IW'(i)) begin
                case (mode)
                    BMX_MODE_CLR: res[i] = 1'b0;
                    BMX_MODE_SET: res[i] = 1'b1;
                    default:      res[i] = val[i] | or_in;
                endcase
            end else begin
                res[i] = val[i];
            end
        end
    end

    assign res_bit = res[idx];

endmodule

// ===== dv/tb_bmx_exec_unit.sv
`timescale 1ns/1ps
module tb_bmx_exec_unit
    import bmx_pkg::*;
;
    // ****************************************
    // Signals and core-side models
    // ****************************************
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        ce       = 1'b1;
    logic        start    = 1'b0;
    logic [7:0]  opcode   = 8'h00;
    logic [7:0]  byte2    = 8'h00;
    logic [7:0]  byte3    = 8'h00;
    logic [15:0] pc_next  = 16'h0000;
    logic [3:0]  reg_ptr  = 4'h0;
    logic [7:0]  flags_r  = 8'h00;
    logic [7:0]  rf [256];
    logic        busy;
    logic [7:0]  rf_raddr;
    logic        rf_we;
    logic [7:0]  rf_waddr;
    logic [7:0]  rf_wdata;
    logic        flags_we;
    logic [7:0]  flags_wdata;
    logic        pc_load;
    logic [15:0] pc_target;
    logic        done;
    int          errors       = 0;
    int          total_checks = 0;

    always #20 clk = ~clk;

    bmx_exec_unit bmx_exec_unit_i (
        .clk(clk), .rst(rst), .ce(ce), .start(start), .opcode(opcode), .byte2(byte2), .byte3(byte3),
        .pc_next(pc_next), .reg_ptr(reg_ptr), .flags_in(flags_r), .rf_rdata(rf[rf_raddr]), .busy(busy),
        .rf_raddr(rf_raddr), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags_we(flags_we),
        .flags_wdata(flags_wdata), .pc_load(pc_load), .pc_target(pc_target), .done(done)
    );

    // Writes repeat while ce holds the pulse; they carry the same value, so that is harmless
    always @(posedge clk) begin
        if (rf_we === 1'b1) rf[rf_waddr] <= rf_wdata;
        if (flags_we === 1'b1) flags_r <= flags_wdata;
    end

    // ****************************************
    // Comparison and closing tasks
    // ****************************************
    task automatic cmp_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // One instruction, expectations worked out beforehand
    // ****************************************
    // Relative branch target: next-instruction address plus the sign-extended displacement
    function automatic logic [15:0] exp_target(input logic [15:0] pcn, input logic [7:0] disp);
        return pcn + {{8{disp[7]}}, disp};
    endfunction

    task automatic run_op(input logic [7:0] opc, input logic [7:0] b2, input logic [7:0] b3,
                          input logic [15:0] pcn, input bit stress);
        logic [3:0] rp;
        logic [7:0] wa;
        logic [7:0] wv;
        logic [7:0] ov;
        logic [7:0] res;
        logic [7:0] xf;
        logic [7:0] xa;
        logic [2:0] b;
        logic       tk;
        logic [3:0] n_exp;
        int         n;
        logic       en;
        rp = 4'($urandom);
        wa = {rp, b2[7:4]};
        b = b2[3:1];
        @(posedge clk);
        start <= 1'b1;
        opcode <= opc;
        byte2 <= b2;
        byte3 <= b3;
        pc_next <= pcn;
        reg_ptr <= rp;
        ce <= 1'b1;
        @(posedge clk);
        start <= stress;
        // The last write of the previous instruction lands by this edge, so operands are read only now
        wv = rf[wa];
        ov = rf[b3];
        res = wv;
        xa = wa;
        tk = (wv[b] == b2[0]);
        xf = flags_r;
        n_exp = CYC_JMP;
        if (opc == OPC_BIT_CS) begin
            res[b] = b2[0];
            n_exp = CYC_CS;
        end else if (opc == OPC_BIT_OR) begin
            if (b2[0] == 1'b0) begin
                res[0] = wv[0] | ov[b];
                xf = (flags_r & FLG_KEEP) | ({7'h00, ~res[0]} << FLG_Z);
            end else begin
                res = ov;
                res[b] = ov[b] | wv[0];
                xa = b3;
                xf = (flags_r & FLG_KEEP) | ({7'h00, ~res[b]} << FLG_Z);
            end
            n_exp = CYC_OR;
        end
        // The edge that takes start is the first of the counted cycles
        n = 1;
        for (int i = 1; i < 60; i++) begin
            en = ce;
            @(posedge clk);
            if (en) n++;
            ce <= stress ? ($urandom % 3 != 0) : 1'b1;
            // A second start while busy must be ignored
            start <= stress && (i < 2);
            #1;
            if (done === 1'b1) break;
            cmp_bit(busy, 1'b1);
            cmp_bit(rf_we | flags_we | pc_load, 1'b0);
        end
        cmp_word(16'(n), {12'h000, n_exp});
        cmp_bit(rf_we, opc != OPC_BIT_JMP);
        cmp_bit(flags_we, opc == OPC_BIT_OR);
        if (opc == OPC_BIT_JMP) begin
            cmp_bit(pc_load, tk);
            cmp_word(pc_target, exp_target(pcn, b3));
        end else begin
            cmp_word({8'h00, rf_waddr}, {8'h00, xa});
            cmp_word({8'h00, rf_wdata}, {8'h00, res});
            cmp_bit(pc_load, 1'b0);
        end
        if (opc == OPC_BIT_OR) cmp_word({8'h00, flags_wdata}, {8'h00, xf});
    endtask

    // ****************************************
    // Test sequence and watchdog
    // ****************************************
    initial begin
        logic [7:0] pick [3];
        void'($urandom(32'hf1ef055a));
        pick = '{OPC_BIT_CS, OPC_BIT_OR, OPC_BIT_JMP};
        for (int k = 0; k < 256; k++) rf[k] = 8'($urandom);
        flags_r = 8'($urandom);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp_bit(busy | done | rf_we | flags_we | pc_load, 1'b0);
        $display("test reset done");
        run_op(OPC_BIT_CS, 8'h10, 8'h00, 16'h0000, 1'b0);
        run_op(OPC_BIT_CS, 8'h2f, 8'h00, 16'h0000, 1'b0);
        run_op(OPC_BIT_OR, 8'h3e, 8'h05, 16'h0000, 1'b0);
        run_op(OPC_BIT_OR, 8'h41, 8'hfa, 16'h0000, 1'b0);
        run_op(OPC_BIT_JMP, 8'h50, 8'h80, 16'h0000, 1'b0);
        run_op(OPC_BIT_JMP, 8'h6f, 8'h7f, 16'hfff0, 1'b0);
        $display("test corner cases done");
        for (int k = 0; k < 150; k++) begin
            run_op(pick[$urandom % 3], 8'($urandom), 8'($urandom), 16'($urandom), k[0]);
        end
        $display("test random instructions done");
        foreach (pick[k]) begin
            @(posedge clk);
            start <= 1'b1;
            // A stressed run may have left the enable low, which would freeze the last done pulse
            ce <= 1'b1;
            opcode <= pick[k] ^ 8'h50;
            @(posedge clk);
            start <= 1'b0;
            repeat (12) begin
                @(posedge clk);
                #1;
                cmp_bit(busy | done, 1'b0);
            end
        end
        $display("test foreign opcodes done");
        @(posedge clk);
        start <= 1'b1;
        opcode <= OPC_BIT_JMP;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            #1;
            cmp_bit(busy | done | pc_load, 1'b0);
        end
        run_op(OPC_BIT_CS, 8'h7e, 8'h00, 16'h0000, 1'b0);
        $display("test reset in mid-run done");
        end_of_test();
    end

    // The run needs about 1500 cycles; this limit leaves wide margin
    initial begin
        #2ms;
        errors++;
        end_of_test();
    end
endmodule
